// ---- hw/ddr_beat_lane.v ----
// Purpose: One data lane of the array write path
// Assumes: Masks are active low and sampled with their beat
// Notes:   Merges the two beats of a write into one lane update
`timescale 1ns/1ns
`default_nettype none
`include "ddr_sram_map.vh"

module ddr_beat_lane (
	input  wire [`LANE_BITS-1:0] old_lane,
	input  wire [`LANE_BITS-1:0] beat1_lane,
	input  wire [`LANE_BITS-1:0] beat2_lane,
	input  wire                  beat1_mask_n,
	input  wire                  beat2_mask_n,
	output reg  [`LANE_BITS-1:0] new_lane
);

	always @* begin
		new_lane = old_lane;
		if (!beat1_mask_n)
			new_lane = beat1_lane;
		// Second beat lands on the odd word half, kept separate by the caller
		if (!beat2_mask_n)
			new_lane = beat2_lane;
	end

endmodule // ddr_beat_lane
`default_nettype wire

// ---- hw/ddr_burst2_sram.v ----
// Purpose: Command decode and burst-of-two data path of a common-I/O DDR SRAM
// Assumes: Both beats of a burst are modelled as two consecutive clk cycles
// Notes:   Array is word pair per address; beat 1 is even half, beat 2 odd half
`timescale 1ns/1ns
`default_nettype none
`include "ddr_sram_map.vh"

module ddr_burst2_sram (
	input  wire                   clk,
	input  wire                   reset_n,
	input  wire                   load_strobe_n,
	input  wire                   read_write_sel,
	input  wire [`ADDR_BITS-1:0]  addr,
	input  wire                   lane0_write_mask_n,
	input  wire                   lane1_write_mask_n,
	input  wire                   termination_select,
	input  wire [`DATA_BITS-1:0]  dq_in,
	output reg  [`DATA_BITS-1:0]  dq_out,
	output reg                    dq_oe_n,
	output reg                    dq_term_on
);

	// ----------------------------------------
	// Storage and pipeline state
	// ----------------------------------------
	localparam [1:0] SLOT_OFF   = 2'h0;
	localparam [1:0] SLOT_BEAT1 = 2'h1;
	localparam [1:0] SLOT_BEAT2 = 2'h2;

	reg  [2*`DATA_BITS-1:0] mem [0:`WORDS-1];
	reg  [1:0]              cmd_nxt;
	reg  [1:0]              cmd_d1_r;
	reg  [1:0]              cmd_d2_r;
	reg  [`ADDR_BITS-1:0]   addr_d1_r;
	reg  [`ADDR_BITS-1:0]   waddr_r;
	reg  [`ADDR_BITS-1:0]   waddr_nxt;
	reg  [`DATA_BITS-1:0]   beat1_data_r;
	reg  [`DATA_BITS-1:0]   beat1_data_nxt;
	reg  [`LANE_COUNT-1:0]  beat1_mask_r;
	reg  [`LANE_COUNT-1:0]  beat1_mask_nxt;
	reg                     wr_beat2_r;
	reg                     wr_beat2_nxt;
	reg  [2*`DATA_BITS-1:0] rd_word_r;
	reg  [`DATA_BITS-1:0]   rd_beat2_r;
	reg  [`DATA_BITS-1:0]   rd_beat2_nxt;
	reg  [1:0]              slot_r;
	reg  [1:0]              slot_nxt;
	reg  [`DATA_BITS-1:0]   dq_out_nxt;
	reg                     dq_oe_n_nxt;
	wire [2*`DATA_BITS-1:0] merged;
	wire [`DATA_BITS-1:0]   rd_lo_word;
	wire [`DATA_BITS-1:0]   rd_hi_word;
	wire [`LANE_COUNT-1:0]  mask_now;
	wire [`LANE_COUNT-1:0]  none_n;
	wire                    abort;
	wire                    do_write;
	wire                    rd_due;

	assign mask_now = {lane1_write_mask_n, lane0_write_mask_n};
	assign none_n   = {`LANE_COUNT{1'b1}};
	assign rd_due   = (cmd_d2_r == `CMD_READ);

	// ----------------------------------------
	// Command decode
	// ----------------------------------------
	always @* begin
		if (load_strobe_n)
			cmd_nxt = `CMD_IDLE;
		else if (read_write_sel)
			cmd_nxt = `CMD_READ;
		else
			cmd_nxt = `CMD_WRITE;
	end

	// ----------------------------------------
	// Command pipeline
	// ----------------------------------------
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			cmd_d1_r <= `CMD_IDLE;
			cmd_d2_r <= `CMD_IDLE;
		end else begin
			cmd_d1_r <= cmd_nxt;
			cmd_d2_r <= cmd_d1_r;
		end
	end

	// Address needs no second stage: the array read is already registered
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			addr_d1_r <= {`ADDR_BITS{1'b0}};
		end else begin
			addr_d1_r <= addr;
		end
	end

	// ----------------------------------------
	// Write beat capture
	// ----------------------------------------
	always @* begin
		waddr_nxt      = waddr_r;
		beat1_data_nxt = beat1_data_r;
		beat1_mask_nxt = beat1_mask_r;
		wr_beat2_nxt   = 1'b0;
		if (cmd_d1_r == `CMD_WRITE) begin
			waddr_nxt      = addr_d1_r;
			beat1_data_nxt = dq_in;
			beat1_mask_nxt = mask_now;
			wr_beat2_nxt   = 1'b1;
		end
	end

	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			waddr_r      <= {`ADDR_BITS{1'b0}};
			beat1_data_r <= {`DATA_BITS{1'b0}};
			beat1_mask_r <= {`LANE_COUNT{1'b1}};
			wr_beat2_r   <= 1'b0;
		end else begin
			waddr_r      <= waddr_nxt;
			beat1_data_r <= beat1_data_nxt;
			beat1_mask_r <= beat1_mask_nxt;
			wr_beat2_r   <= wr_beat2_nxt;
		end
	end

	// ----------------------------------------
	// Write lane merge, two instances per lane (one per word half)
	// ----------------------------------------
	genvar g;
	generate
		for (g = 0; g < `LANE_COUNT; g = g + 1) begin : g_lane
			// Beat 1 updates even half, beat 2 odd half of the stored pair
			ddr_beat_lane u_lo (
				.old_lane     (mem[waddr_r][g*`LANE_BITS +: `LANE_BITS]),
				.beat1_lane   (beat1_data_r[g*`LANE_BITS +: `LANE_BITS]),
				.beat2_lane   (beat1_data_r[g*`LANE_BITS +: `LANE_BITS]),
				.beat1_mask_n (beat1_mask_r[g]),
				.beat2_mask_n (1'b1),
				.new_lane     (merged[g*`LANE_BITS +: `LANE_BITS])
			);
			ddr_beat_lane u_hi (
				.old_lane     (mem[waddr_r][`DATA_BITS + g*`LANE_BITS +: `LANE_BITS]),
				.beat1_lane   (dq_in[g*`LANE_BITS +: `LANE_BITS]),
				.beat2_lane   (dq_in[g*`LANE_BITS +: `LANE_BITS]),
				.beat1_mask_n (1'b1),
				.beat2_mask_n (mask_now[g]),
				.new_lane     (merged[`DATA_BITS + g*`LANE_BITS +: `LANE_BITS])
			);
		end
	endgenerate

	// ----------------------------------------
	// Array write
	// ----------------------------------------
	// Abort skips the array write entirely
	assign abort    = (beat1_mask_r == none_n) && (mask_now == none_n);
	assign do_write = wr_beat2_r && !abort;

	always @(posedge clk) begin
		if (do_write)
			mem[waddr_r] <= merged;
	end

	// ----------------------------------------
	// Array read
	// ----------------------------------------
	// One cycle after the command; a write finishing in the same cycle is not seen
	always @(posedge clk) begin
		if (cmd_d1_r == `CMD_READ)
			rd_word_r <= mem[addr_d1_r];
	end

	genvar r;
	generate
		for (r = 0; r < `LANE_COUNT; r = r + 1) begin : g_rd_lane
			assign rd_lo_word[r*`LANE_BITS +: `LANE_BITS] = rd_word_r[r*`LANE_BITS +: `LANE_BITS];
			assign rd_hi_word[r*`LANE_BITS +: `LANE_BITS] = rd_word_r[`DATA_BITS + r*`LANE_BITS +: `LANE_BITS];
		end
	endgenerate

	// ----------------------------------------
	// Output slot sequencer
	// ----------------------------------------
	// Beats are whole cycles, so a read in the cycle right after another read
	// collides with its second beat; the running burst wins and the new one is lost
	always @* begin
		case (slot_r)
			SLOT_OFF: begin
				if (rd_due)
					slot_nxt = SLOT_BEAT1;
				else
					slot_nxt = SLOT_OFF;
			end
			SLOT_BEAT1: begin
				slot_nxt = SLOT_BEAT2;
			end
			SLOT_BEAT2: begin
				if (rd_due)
					slot_nxt = SLOT_BEAT1;
				else
					slot_nxt = SLOT_OFF;
			end
			default: begin
				slot_nxt = SLOT_OFF;
			end
		endcase
	end

	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			slot_r <= SLOT_OFF;
		end else begin
			slot_r <= slot_nxt;
		end
	end

	// ----------------------------------------
	// Read data and driver control
	// ----------------------------------------
	always @* begin
		dq_out_nxt   = dq_out;
		rd_beat2_nxt = rd_beat2_r;
		dq_oe_n_nxt  = 1'b1;
		case (slot_nxt)
			SLOT_BEAT1: begin
				dq_out_nxt   = rd_lo_word;
				rd_beat2_nxt = rd_hi_word;
				dq_oe_n_nxt  = 1'b0;
			end
			SLOT_BEAT2: begin
				dq_out_nxt  = rd_beat2_r;
				dq_oe_n_nxt = 1'b0;
			end
			default: begin
				dq_oe_n_nxt = 1'b1;
			end
		endcase
	end

	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			dq_out     <= {`DATA_BITS{1'b0}};
			dq_oe_n    <= 1'b1;
			rd_beat2_r <= {`DATA_BITS{1'b0}};
		end else begin
			dq_out     <= dq_out_nxt;
			dq_oe_n    <= dq_oe_n_nxt;
			rd_beat2_r <= rd_beat2_nxt;
		end
	end

	// ----------------------------------------
	// Termination level
	// ----------------------------------------
	// Mirrored every cycle; only meaningful while the drivers are off
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			dq_term_on <= 1'b0;
		end else begin
			dq_term_on <= termination_select;
		end
	end

endmodule // ddr_burst2_sram
`default_nettype wire

// ---- include/ddr_sram_map.vh ----
// Purpose: Constants for the burst-of-two common-I/O SRAM model
// Assumes: One clock, one word per beat; beats are whole clock cycles
// Notes:   Widths fixed at the 18-bit configuration
`ifndef DDR_SRAM_MAP_VH
`define DDR_SRAM_MAP_VH

`define LANE_BITS        9
`define LANE_COUNT       2
`define DATA_BITS        18
`define ADDR_BITS        6
`define WORDS            64
`define READ_LATENCY     2
`define DRIVE_OFF_DELAY  2
`define CMD_IDLE         2'h0
`define CMD_WRITE        2'h1
`define CMD_READ         2'h2

`endif

// ---- testbench/sram_ctl.sv ----
// Purpose: controller model; Assumes: drives on falling clk; Notes: unused lines get fresh noise
`timescale 1ns/1ns
`default_nettype none
module sram_ctl(input wire logic clk,output logic load_strobe_n,read_write_sel,termination_select,
	output logic [5:0] addr,output logic lane0_write_mask_n,lane1_write_mask_n,output logic [17:0] dq_in);
	initial {load_strobe_n,read_write_sel,termination_select,addr,lane1_write_mask_n,lane0_write_mask_n,dq_in}=29'h10000000;
	task cyc(input logic l,r,input logic [5:0] a,input logic [1:0] m,input logic [17:0] d);
		@(negedge clk);
		{load_strobe_n,read_write_sel,addr,lane1_write_mask_n,lane0_write_mask_n,dq_in}={l,r,a,m,d};
		termination_select=$urandom;
	endtask
endmodule // sram_ctl
`default_nettype wire

// ---- testbench/sram_props_properties.sv ----
// Purpose: pin timing checks; Assumes: one clock; Notes: data values are scored by the bench
`timescale 1ns/1ns
`default_nettype none
module sram_props(input wire logic clk,reset_n,load_strobe_n,read_write_sel,termination_select,dq_oe_n,dq_term_on);
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	wire rd = !load_strobe_n && read_write_sel;
	wire wr = !load_strobe_n && !read_write_sel;
	property p_rd; rd |-> ##3 !dq_oe_n[*2]; endproperty
	a_rd: assert property(p_rd) else $error("read beats missing");
	property p_rr; rd ##1 load_strobe_n ##1 rd |-> ##1 !dq_oe_n[*4]; endproperty
	a_rr: assert property(p_rr) else $error("back to back reads broken");
	property p_hold; rd ##1 load_strobe_n[*2] |=> !dq_oe_n[*2] ##1 dq_oe_n; endproperty
	a_hold: assert property(p_hold) else $error("read cut by deselect");
	property p_idle; load_strobe_n[*4] |=> dq_oe_n; endproperty
	a_idle: assert property(p_idle) else $error("drive while deselected");
	property p_doff; load_strobe_n && !$past(rd) |-> ##3 dq_oe_n; endproperty
	a_doff: assert property(p_doff) else $error("no off slot after deselect");
	property p_woff; wr && !$past(rd) |-> ##3 dq_oe_n; endproperty
	a_woff: assert property(p_woff) else $error("no off slot after write");
	property p_tdes; load_strobe_n && !$past(rd) |-> ##3 dq_oe_n && dq_term_on == $past(termination_select); endproperty
	a_tdes: assert property(p_tdes) else $error("termination level wrong");
	property p_twr; wr |-> ##3 dq_term_on == $past(termination_select); endproperty
	a_twr: assert property(p_twr) else $error("termination level wrong");
endmodule // sram_props
`default_nettype wire

// ---- testbench/test_ddr_burst2_sram.sv ----
// Purpose: random traffic against a shadow array; Assumes: 100 MHz clk; Notes: reads scored in order
`timescale 1ns/1ns
`default_nettype none
module test_ddr_burst2_sram;
	logic clk=0,reset_n=0,load_strobe_n,read_write_sel,termination_select,lane0_write_mask_n,lane1_write_mask_n;
	logic dq_oe_n,dq_term_on;
	logic [5:0] addr;
	logic [17:0] dq_in,dq_out,exp;
	logic [35:0] mem[64];
	logic [17:0] q[$];
	int fails=0,compares=0;
	ddr_burst2_sram u_dut(.clk(clk),.reset_n(reset_n),.load_strobe_n(load_strobe_n),.read_write_sel(read_write_sel),
		.addr(addr),.lane0_write_mask_n(lane0_write_mask_n),.lane1_write_mask_n(lane1_write_mask_n),
		.termination_select(termination_select),.dq_in(dq_in),.dq_out(dq_out),.dq_oe_n(dq_oe_n),
		.dq_term_on(dq_term_on));
	sram_ctl u_ctl(.clk(clk),.load_strobe_n(load_strobe_n),.read_write_sel(read_write_sel),
		.termination_select(termination_select),.addr(addr),.lane0_write_mask_n(lane0_write_mask_n),
		.lane1_write_mask_n(lane1_write_mask_n),.dq_in(dq_in));
	initial forever #5 clk=~clk;
	always @(negedge clk) if (dq_oe_n===1'b0) begin
		exp=q.size()?q.pop_front():'x;
		compares++;
		if (dq_out!==exp) begin
			fails++;
			$display("ERROR dq_out exp %h got %h",exp,dq_out);
		end
	end
	task idle; u_ctl.cyc(1,$urandom,$urandom,$urandom,$urandom); endtask
	task rd(input logic [5:0] a);
		u_ctl.cyc(0,1,a,$urandom,$urandom);
		q.push_back(mem[a][17:0]);
		q.push_back(mem[a][35:18]);
		idle;
	endtask
	task wr(input logic [5:0] a,input logic [3:0] m,input logic [35:0] d);
		repeat(3) idle;
		u_ctl.cyc(0,0,a,$urandom,$urandom);
		u_ctl.cyc(1,$urandom,$urandom,m[1:0],d[17:0]);
		u_ctl.cyc(1,$urandom,$urandom,m[3:2],d[35:18]);
		for (int i=0;i<4;i++) if (!m[i]) mem[a][9*i+:9]=d[9*i+:9];
	endtask
	task tally_and_finish;
		$display("fails=%0d compares=%0d",fails,compares);
		if (fails==0 && compares>0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	initial begin
		void'($urandom(67440));
		repeat(5) @(negedge clk);
		compares++;
		if (dq_out!==18'h00000 || dq_oe_n!==1'b1 || dq_term_on!==1'b0) begin
			fails++;
			$display("ERROR reset outputs exp 00000/1/0 got %h/%b/%b",dq_out,dq_oe_n,dq_term_on);
		end
		reset_n=1;
		for (int a=0;a<64;a++) wr(a,4'h0,{$urandom,$urandom});
		wr(6'h5,4'hF,36'h0);
		rd(6'h5);
		repeat(200) case ($urandom%3)
			0: wr($urandom,$urandom,{$urandom,$urandom});
			1: rd($urandom);
			default: idle;
		endcase
		repeat(6) idle;
		if (q.size()!=0) begin
			fails++;
			$display("ERROR pending reads exp 0 got %0d",q.size());
		end
		tally_and_finish;
	end
endmodule // test_ddr_burst2_sram
bind ddr_burst2_sram sram_props u_p(.clk(clk),.reset_n(reset_n),.load_strobe_n(load_strobe_n),
	.read_write_sel(read_write_sel),.termination_select(termination_select),.dq_oe_n(dq_oe_n),
	.dq_term_on(dq_term_on));
`default_nettype wire
